// [sbc_irq_consts.svh]
`ifndef SBC_IRQ_CONSTS_SVH
`define SBC_IRQ_CONSTS_SVH

// Register addresses on the serial control port.
`define ADDR_GLOBAL 8'h60
`define ADDR_SYSTEM 8'h61
`define ADDR_SUPPLY 8'h62
`define ADDR_TRX 8'h63
`define ADDR_B0_WAKE 8'h64
`define ADDR_B0_FAIL 8'h65
`define ADDR_B1_WAKE 8'h66
`define ADDR_B1_FAIL 8'h67

// Implemented bits of each status register; reserved bits read as zero.
`define VALID_SYSTEM 8'h37
`define VALID_SUPPLY 8'h3f
`define VALID_TRX 8'h3c
`define VALID_BANK 8'hff
`define VALID_GLOBAL 8'h7f
`define PENDING_RESET 8'h00

// Bits that have no enable and are always active.
`define ALWAYS_ON_SYSTEM 8'h31
`define ALWAYS_ON_TRX 8'h20

// Bits that also drive the secondary interrupt output.
`define SECOND_SYSTEM 8'h24
`define SECOND_SUPPLY 8'h39

// System register bit positions.
`define SYS_OVSD 5
`define SYS_POWER_ON 4
`define SYS_OVERTEMP 2
`define SYS_SPI_FAIL 1
`define SYS_WATCHDOG 0

// Supply register bit positions.
`define SUP_CONVERTER 5
`define SUP_BAT_OVER 4
`define SUP_BAT_UNDER 3
`define SUP_EXT_OVER 2
`define SUP_EXT_UNDER 1
`define SUP_MAIN_UNDER 0

// Transceiver register bit positions.
`define TRX_PN_ERROR 5
`define TRX_SILENCE 4
`define TRX_LIN2 3
`define TRX_LIN1 2

// Bus silence timeout and clock rate.
`define SILENCE_TIMEOUT_US 1000
`define CLOCK_MHZ 20

`endif

// [sbc_irq_pkg.sv]
package sbc_irq_pkg;

  // Single-cycle event pulses from on-chip logic on the same clock.
  typedef struct packed {
    logic watchdog;
    logic spiFail;
    logic powerOn;
    logic pnFrameError;
    logic linWake1;
    logic linWake2;
  } logicEvents_s;

  // Comparator and pin levels that come from outside the clock domain.
  typedef struct packed {
    logic overTemp;
    logic batOver;
    logic batUnder;
    logic ovShutdown;
    logic extOver;
    logic extUnder;
    logic mainUnder;
    logic convFlag;
    logic canRecessive;
  } analogLevels_s;

  // Enable bits kept by the enable registers outside this block.
  typedef struct packed {
    logic [7:0] sys;
    logic [7:0] sup;
    logic [7:0] trx;
    logic [7:0] b0Wake;
    logic [7:0] b0Fail;
    logic [7:0] b1Wake;
    logic [7:0] b1Fail;
  } enables_s;

  typedef logic [7:0] regByte_t;

endpackage

// [pending_reg.sv]
`timescale 1ns/1ps
`include "sbc_irq_consts.svh"

// One status register of sticky pending bits, cleared by writing one.
module pending_reg #(
  parameter logic [7:0] VALID = 8'hff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Set and clear requests
  input wire logic [7:0] setBits,
  input wire logic [7:0] clrBits,
  // Pending bits
  output logic [7:0] pending
);

  logic [7:0] pend_r;
  logic [7:0] pend_nxt;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    pend_nxt = ((pend_r & ~clrBits) | setBits) & VALID;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_r <= `PENDING_RESET;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign pending = pend_r;

endmodule

// [sbc_interrupt_status_bank.sv]
// What this block does
// - Battery overvoltage latches pending, drives both outputs.
// - Shutdown overvoltage sets pending, both outputs, overload.
// - Converter flag change either way sets pending.
// - Open load with driver active, primary only.
// - Short circuit with driver active, primary only.
// - Rising wake edge on wake pin, primary.
// - Falling wake edge on wake pin, primary.
// - Read-only summary: one bit per status register.
// - System register bit layout, three always enabled.
// - Supply register bit layout, top bits reserved.
// - Transceiver register bit layout, top bits reserved.
// - Bus silent beyond timeout sets silence pending.
// - Secondary output asserts at once, no delay.
// - Four sources have no enable, always active.
`timescale 1ns/1ps
`include "sbc_irq_consts.svh"

module sbc_interrupt_status_bank #(
  parameter int HV_PINS = 8,
  parameter int SILENCE_CYCLES = `SILENCE_TIMEOUT_US * `CLOCK_MHZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register access from the serial control port
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Event sources
  input wire sbc_irq_pkg::logicEvents_s logicEvents,
  input wire sbc_irq_pkg::analogLevels_s analogLevels,
  input wire logic [HV_PINS-1:0] hvRiseEdge,
  input wire logic [HV_PINS-1:0] hvFallEdge,
  input wire logic [HV_PINS-1:0] hvOpenLoad,
  input wire logic [HV_PINS-1:0] hvShort,
  input wire logic [HV_PINS-1:0] hvDriverOn,
  input wire logic [HV_PINS-1:0] hvWakeCfg,
  // Enables from the enable registers
  input wire sbc_irq_pkg::enables_s enables,
  // Interrupt and mode outputs
  output logic primaryIrqN,
  output logic secondaryIrqN,
  output logic overloadReq
);

  localparam int NREG = 7;
  localparam int LW = $bits(sbc_irq_pkg::analogLevels_s);

  // Two-stage synchronisers plus a third stage for edge detection.
  logic [LW-1:0] syncA_r, syncB_r, prev_r;
  logic [LW-1:0] syncA_nxt, syncB_nxt, prev_nxt;
  sbc_irq_pkg::analogLevels_s lvl, lvlPrev;

  always_comb begin
    syncA_nxt = analogLevels;
    syncB_nxt = syncA_r;
    prev_nxt = syncB_r;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
      prev_r <= '0;
    end else begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign lvl = syncB_r;
  assign lvlPrev = prev_r;

  // Silence counter; any dominant bit restarts it, and it fires once per quiet spell.
  logic [31:0] silCnt_r, silCnt_nxt;
  logic silenceHit;

  always_comb begin
    silCnt_nxt = silCnt_r;
    silenceHit = 1'b0;
    if (!lvl.canRecessive) begin
      silCnt_nxt = '0;
    end else if (silCnt_r < 32'(SILENCE_CYCLES)) begin
      silCnt_nxt = silCnt_r + 32'h1;
    end else if (silCnt_r == 32'(SILENCE_CYCLES)) begin
      silenceHit = 1'b1;
      silCnt_nxt = silCnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      silCnt_r <= '0;
    end else begin
      silCnt_r <= silCnt_nxt;
    end
  end

  // Set requests per register. Comparator sources latch on their rising edge, the converter flag on either edge.
  logic [7:0] setReg [NREG];
  logic [7:0] clrReg [NREG];
  logic [7:0] pendReg [NREG];
  logic [7:0] enReg [NREG];
  logic [7:0] secReg [NREG];
  logic [7:0] addrOf [NREG];
  logic [7:0] validOf [NREG];
  logic [HV_PINS-1:0] wakeR, wakeF, failO, failS;

  assign wakeR = hvRiseEdge & hvWakeCfg;
  assign wakeF = hvFallEdge & hvWakeCfg;
  assign failO = hvOpenLoad & hvDriverOn;
  assign failS = hvShort & hvDriverOn;

  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      setReg[r] = '0;
    end
    setReg[0][`SYS_OVSD] = lvl.ovShutdown & ~lvlPrev.ovShutdown;
    setReg[0][`SYS_POWER_ON] = logicEvents.powerOn;
    setReg[0][`SYS_OVERTEMP] = lvl.overTemp & ~lvlPrev.overTemp;
    setReg[0][`SYS_SPI_FAIL] = logicEvents.spiFail;
    setReg[0][`SYS_WATCHDOG] = logicEvents.watchdog;
    setReg[1][`SUP_CONVERTER] = lvl.convFlag ^ lvlPrev.convFlag;
    setReg[1][`SUP_BAT_OVER] = lvl.batOver & ~lvlPrev.batOver;
    setReg[1][`SUP_BAT_UNDER] = lvl.batUnder & ~lvlPrev.batUnder;
    setReg[1][`SUP_EXT_OVER] = lvl.extOver & ~lvlPrev.extOver;
    setReg[1][`SUP_EXT_UNDER] = lvl.extUnder & ~lvlPrev.extUnder;
    setReg[1][`SUP_MAIN_UNDER] = lvl.mainUnder & ~lvlPrev.mainUnder;
    setReg[2][`TRX_PN_ERROR] = logicEvents.pnFrameError;
    setReg[2][`TRX_SILENCE] = silenceHit;
    setReg[2][`TRX_LIN2] = logicEvents.linWake2;
    setReg[2][`TRX_LIN1] = logicEvents.linWake1;
    // Bank bits: even position is rise or open load, odd is fall or short.
    for (int p = 0; p < HV_PINS && p < 8; p++) begin
      setReg[3 + 2 * (p / 4)][2 * (p % 4)] = wakeR[p];
      setReg[3 + 2 * (p / 4)][2 * (p % 4) + 1] = wakeF[p];
      setReg[4 + 2 * (p / 4)][2 * (p % 4)] = failO[p];
      setReg[4 + 2 * (p / 4)][2 * (p % 4) + 1] = failS[p];
    end
  end

  // Always-on sources ignore their enable bit.
  assign enReg[0] = enables.sys | `ALWAYS_ON_SYSTEM;
  assign enReg[1] = enables.sup;
  assign enReg[2] = enables.trx | `ALWAYS_ON_TRX;
  assign enReg[3] = enables.b0Wake;
  assign enReg[4] = enables.b0Fail;
  assign enReg[5] = enables.b1Wake;
  assign enReg[6] = enables.b1Fail;
  assign secReg = '{`SECOND_SYSTEM, `SECOND_SUPPLY, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  assign addrOf = '{`ADDR_SYSTEM, `ADDR_SUPPLY, `ADDR_TRX, `ADDR_B0_WAKE, `ADDR_B0_FAIL,
                    `ADDR_B1_WAKE, `ADDR_B1_FAIL};
  assign validOf = '{`VALID_SYSTEM, `VALID_SUPPLY, `VALID_TRX, `VALID_BANK, `VALID_BANK,
                     `VALID_BANK, `VALID_BANK};

  // One sticky register per status address; writing one clears a bit.
  logic [7:0] summary;
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gReg
      assign clrReg[g] = (regWrEn && regAddr == addrOf[g]) ? regWrData : 8'h00;
      pending_reg #(
        .VALID(g == 0 ? `VALID_SYSTEM : g == 1 ? `VALID_SUPPLY : g == 2 ? `VALID_TRX
               : `VALID_BANK)
      ) uPend (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .setBits(setReg[g]),
        .clrBits(clrReg[g]),
        .pending(pendReg[g])
      );
      // Summary order from bit 0: system, supply, transceiver, banks.
      assign summary[g] = |pendReg[g];
    end
  endgenerate
  assign summary[7] = 1'b0;

  // Output registers. The secondary output has no delay timer in its path.
  logic priAct, secAct;
  logic [7:0] rd_r, rd_nxt;
  logic priN_r, priN_nxt, secN_r, secN_nxt, ovl_r, ovl_nxt;

  always_comb begin
    priAct = 1'b0;
    secAct = 1'b0;
    for (int r = 0; r < NREG; r++) begin
      priAct = priAct | (|(pendReg[r] & enReg[r]));
      secAct = secAct | (|(pendReg[r] & enReg[r] & secReg[r]));
    end
    priN_nxt = ~priAct;
    secN_nxt = ~secAct;
    ovl_nxt = setReg[0][`SYS_OVSD];
    rd_nxt = rd_r;
    if (regRdEn) begin
      rd_nxt = 8'h00;
      if (regAddr == `ADDR_GLOBAL) begin
        rd_nxt = summary & `VALID_GLOBAL;
      end
      for (int r = 0; r < NREG; r++) begin
        if (regAddr == addrOf[r]) begin
          rd_nxt = pendReg[r] & validOf[r];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      priN_r <= 1'b1;
      secN_r <= 1'b1;
      ovl_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      priN_r <= priN_nxt;
      secN_r <= secN_nxt;
      ovl_r <= ovl_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign primaryIrqN = priN_r;
  assign secondaryIrqN = secN_r;
  assign overloadReq = ovl_r;
  assign regRdData = rd_r;

  // Checks.
  sequence sBatOverRise;
    lvl.batOver && !lvlPrev.batOver;
  endsequence
  sequence sBothLowNext;
    ##1 pendReg[1][`SUP_BAT_OVER]
    ##1 ((!primaryIrqN && !secondaryIrqN) || !enReg[1][`SUP_BAT_OVER]);
  endsequence

  a_bat_over_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    sBatOverRise |-> sBothLowNext)
    else $error("battery overvoltage not latched or signalled");

  a_ovsd_overload: assert property (@(posedge mclk) disable iff (sys_rst)
    (lvl.ovShutdown && !lvlPrev.ovShutdown) |=> overloadReq && pendReg[0][`SYS_OVSD]
    ##1 !secondaryIrqN)
    else $error("shutdown did not raise overload and secondary output");

  a_conv_change: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(lvl.convFlag) |=> pendReg[1][`SUP_CONVERTER])
    else $error("converter change not latched");

  a_open_load: assert property (@(posedge mclk) disable iff (sys_rst)
    ((|hvOpenLoad) && !(|hvDriverOn) && pendReg[4] == 8'h00 && pendReg[6] == 8'h00
    && !regWrEn) |=> (pendReg[4] == 8'h00 && pendReg[6] == 8'h00))
    else $error("open load latched with driver off");

  a_summary_bits: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRdEn && regAddr == `ADDR_GLOBAL) |=> (regRdData[7] == 1'b0)
    && (regRdData[2:0] == {|$past(pendReg[2]), |$past(pendReg[1]), |$past(pendReg[0])}))
    else $error("summary read mismatch");

  a_sticky_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (pendReg[1][`SUP_BAT_UNDER] && !(regWrEn && regAddr == `ADDR_SUPPLY)) |=>
    pendReg[1][`SUP_BAT_UNDER])
    else $error("pending bit lost without clear");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (pendReg[0] & ~`VALID_SYSTEM) == 8'h00 && (pendReg[2] & ~`VALID_TRX) == 8'h00)
    else $error("reserved bit set");

  a_always_on_wd: assert property (@(posedge mclk) disable iff (sys_rst)
    pendReg[0][`SYS_WATCHDOG] |=> !primaryIrqN)
    else $error("watchdog pending did not assert primary output");

  a_silence_set: assert property (@(posedge mclk) disable iff (sys_rst)
    (silCnt_r == 32'(SILENCE_CYCLES) && lvl.canRecessive) |=> pendReg[2][`TRX_SILENCE])
    else $error("bus silence not latched at timeout");

  a_release_out: assert property (@(posedge mclk) disable iff (sys_rst)
    (!priAct) |=> primaryIrqN)
    else $error("primary output held with nothing pending");

endmodule

// [sbc_host_model.sv]
`timescale 1ns/1ps

// Host side of the register port: one-cycle read and write strobes.
module sbc_host_model (
  // Clock
  input wire logic mclk,
  // Register port toward the device
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  // High in the cycle where read data is valid
  output logic rdValid
);
  // Strobes start low so nothing is requested while reset is held.
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    rdValid = 1'b0;
  end

  // Read data is registered, so it is valid one cycle after the strobe.
  always @(posedge mclk) begin
    rdValid <= regRdEn;
  end

  // One read strobe; the strobe drops at the edge that takes it.
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
  endtask

  // A one clears that pending bit, so a stray one loses an event.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask
endmodule

// [test_sbc_interrupt_status_bank.sv]
`timescale 1ns/1ps

module test_sbc_interrupt_status_bank;
  // Short silence count keeps the run brief.
  localparam int SIL = 16;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, rdValid, primaryIrqN, secondaryIrqN, overloadReq;
  sbc_irq_pkg::logicEvents_s logicEvents = '0;
  sbc_irq_pkg::analogLevels_s analogLevels = '0;
  sbc_irq_pkg::enables_s enables = '1;
  logic [7:0] hvRiseEdge = 8'h00, hvFallEdge = 8'h00, hvOpenLoad = 8'h00, hvShort = 8'h00;
  logic [7:0] hvDriverOn = 8'hff, hvWakeCfg = 8'hff;
  logic [9:0] expQ[$];
  logic [9:0] expV;
  int err_total = 0, cmp_count = 0, ovlCount = 0, testNo = 0, i, p;

  // Free-running 20 MHz clock.
  always #25 mclk = ~mclk;

  sbc_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .rdValid(rdValid));

  sbc_interrupt_status_bank #(.HV_PINS(8), .SILENCE_CYCLES(SIL)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .logicEvents(logicEvents),
    .analogLevels(analogLevels), .hvRiseEdge(hvRiseEdge), .hvFallEdge(hvFallEdge),
    .hvOpenLoad(hvOpenLoad), .hvShort(hvShort), .hvDriverOn(hvDriverOn),
    .hvWakeCfg(hvWakeCfg), .enables(enables), .primaryIrqN(primaryIrqN),
    .secondaryIrqN(secondaryIrqN), .overloadReq(overloadReq));

  // Each read result is judged against the oldest note left by the driver.
  always @(posedge mclk) begin
    if (overloadReq === 1'b1) ovlCount++;
    if (rdValid === 1'b1) begin
      expV = (expQ.size() != 0) ? expQ.pop_front() : 10'hxxx;
      cmp_count++;
      if ({primaryIrqN, secondaryIrqN, regRdData} !== expV) begin
        err_total++;
        $display("unexpected at %0t: got %h expected %h", $time,
          {primaryIrqN, secondaryIrqN, regRdData}, expV);
      end
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Expected value is {primary, secondary, read byte}.
  task automatic check_rd(input logic [7:0] a, input logic [9:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask

  // Kind 0 pulses a logic event, 1 raises a level, 2 pulses a pin event, 3 toggles.
  task automatic fire(input int kind, input int idx);
    @(posedge mclk);
    case (kind)
      0: logicEvents <= 6'(1 << idx);
      1: analogLevels[idx] <= 1'b1;
      3: analogLevels[idx] <= ~analogLevels[idx];
      default: {hvRiseEdge, hvFallEdge, hvOpenLoad, hvShort} <= 32'(1) << (8 * (3 - idx % 4) + idx / 4);
    endcase
    @(posedge mclk);
    logicEvents <= '0;
    {hvRiseEdge, hvFallEdge, hvOpenLoad, hvShort} <= 32'h0;
  endtask

  // Latch, summary, write of zero, clear by one; a level stays high over the clear.
  task automatic run_src(input int kind, input int idx, input logic [7:0] a, input int b,
                         input logic pri, input logic sec);
    fire(kind, idx);
    repeat (6) @(posedge mclk);
    check_rd(a, {pri, sec, 8'(1 << b)});
    check_rd(8'h60, {pri, sec, 8'(1 << (a - 8'h61))});
    // The summary is read-only, so a write of ones there must not clear anything.
    host.wr(8'h60, 8'hff);
    host.wr(a, ~8'(1 << b));
    repeat (3) @(posedge mclk);
    check_rd(a, {pri, sec, 8'(1 << b)});
    host.wr(a, 8'(1 << b));
    repeat (3) @(posedge mclk);
    check_rd(a, 10'h300);
    if (kind == 1) analogLevels[idx] <= 1'b0;
    testNo++;
    $display("test %0d done", testNo);
  endtask

  initial begin
    void'($urandom(70));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    check_rd(8'h70, 10'h300);
    for (i = 0; i < 4; i++) check_rd(8'h60 + 8'(i), 10'h300);
    // With every enable off only the always-active sources may reach the outputs.
    enables <= '0;
    run_src(0, 5, 8'h61, 0, 1'b0, 1'b1);
    run_src(0, 4, 8'h61, 1, 1'b1, 1'b1);
    run_src(1, 8, 8'h61, 2, 1'b1, 1'b1);
    run_src(0, 2, 8'h63, 5, 1'b0, 1'b1);
    run_src(0, 3, 8'h61, 4, 1'b0, 1'b1);
    run_src(1, 5, 8'h61, 5, 1'b0, 1'b0);
    enables <= '1;
    run_src(0, 4, 8'h61, 1, 1'b0, 1'b1);
    run_src(0, 1, 8'h63, 2, 1'b0, 1'b1);
    run_src(0, 0, 8'h63, 3, 1'b0, 1'b1);
    run_src(1, 8, 8'h61, 2, 1'b0, 1'b0);
    run_src(1, 7, 8'h62, 4, 1'b0, 1'b0);
    run_src(1, 6, 8'h62, 3, 1'b0, 1'b0);
    run_src(1, 4, 8'h62, 2, 1'b0, 1'b1);
    run_src(1, 3, 8'h62, 1, 1'b0, 1'b1);
    run_src(1, 2, 8'h62, 0, 1'b0, 1'b0);
    run_src(3, 1, 8'h62, 5, 1'b0, 1'b0);
    run_src(3, 1, 8'h62, 5, 1'b0, 1'b0);
    // Rise, fall, open load and short on random pins.
    for (i = 0; i < 4; i++) begin
      p = $urandom % 8;
      run_src(2, p * 4 + i, 8'h64 + 8'(2 * (p / 4) + i / 2), 2 * (p % 4) + i % 2, 1'b0, 1'b1);
    end
    // Pin events without wake configuration or active driver are ignored.
    hvWakeCfg <= 8'h00;
    hvDriverOn <= 8'h00;
    p = $urandom % 8;
    for (i = 0; i < 4; i++) fire(2, p * 4 + i);
    repeat (6) @(posedge mclk);
    check_rd(8'h60, 10'h300);
    testNo++;
    $display("test %0d done", testNo);
    hvWakeCfg <= 8'hff;
    hvDriverOn <= 8'hff;
    // Bus silence latches once after the timeout and not again while silent.
    analogLevels[0] <= 1'b1;
    repeat (12) @(posedge mclk);
    check_rd(8'h63, 10'h300);
    repeat (12) @(posedge mclk);
    check_rd(8'h63, 10'h110);
    host.wr(8'h63, 8'h10);
    repeat (30) @(posedge mclk);
    check_rd(8'h63, 10'h300);
    analogLevels[0] <= 1'b0;
    testNo++;
    $display("test %0d done", testNo);
    repeat (3) @(posedge mclk);
    cmp_count++;
    if (ovlCount != 1) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, ovlCount, 1);
    end
    stop_test();
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    stop_test();
  end
endmodule
